// ==== common/scsc_pkg.sv ====
package scsc_pkg;

  // Slot-role strap codes (jumper position pairs 1-2, 3-4, 5-6)
  localparam logic [1:0] ROLE_NON_SC = 2'h0;
  localparam logic [1:0] ROLE_AUTO   = 2'h1;
  localparam logic [1:0] ROLE_SC     = 2'h2;

  // Reference clock and boot figures
  localparam int SYSCLK_MHZ      = 16;
  localparam int REFCLK_MHZ      = 10;
  localparam int CLK_MHZ         = 20;
  localparam int RM_DEADLINE_S   = 5;
  localparam int RM_DEADLINE_CYC = RM_DEADLINE_S * CLK_MHZ * 1000000;

  // Bus arbitration defaults
  localparam logic [1:0] DEF_REQ_LEVEL = 2'h3;
  localparam int         REQ_LEVELS    = 4;

  // Register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STRAPS = 8'h08;
  localparam logic [7:0] OFS_ARB    = 8'h0c;

  // Control reset: fair=1, release-on-request=1, prioritized=1, timeout=0, level=3
  localparam logic [31:0] CTRL_RST = 32'h0000_0073;

  // EEPROM layout
  localparam int              CFG_WORDS   = 8;
  localparam logic [7:0]      FACTORY_BASE = 8'h00;
  localparam logic [7:0]      USER_BASE    = 8'h08;

  typedef struct packed {
    logic [1:0] slot_role_strap;
    logic       clock_source_strap;
    logic       external_clock_choice_strap;
    logic       coax_clock_direction_strap;
    logic       port_clock_direction_strap;
    logic       boot_image_select_strap;
    logic       self_config_disable_strap;
  } scsc_straps_t;

  typedef struct packed {
    logic sysclk_en;
    logic refclk_bp_drive;
    logic refclk_use_ext;
    logic refclk_ext_port;
    logic coax_out;
    logic port_out;
  } scsc_clk_t;

endpackage

// ==== src/scsc_top.sv ====
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
// What this block does
// - Three-way slot role strap: forced non-controller, auto detect, forced controller.
// - In auto mode, take controller role only when sitting in first slot.
// - As controller, arbiter grants highest requesting level of four; the owner keeps the grant until it drops its request.
// - As controller, drive backplane system clock from 16 MHz oscillator.
// - As controller drive reference clock out differentially; otherwise only receive.
// - Clock source strap picks internal or external; second strap picks coax or port.
// - Direction straps set port and coax reference clock paths, input by default.
// - Boot-image strap chooses factory or user EEPROM half; user by default.
// - Loader copies stored values into registers, ready well before 5 s deadline.
// - Self-config disable strap suppresses the load; backplane stays unconfigured.
// - Default: fair requester on level 3, release on request, prioritized, no timeout.
module scsc_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Straps and slot detect
  input  wire scsc_pkg::scsc_straps_t straps_i,
  input  wire logic                 first_slot_i,
  // Backplane bus requests
  input  wire logic [3:0]           bus_req_i,
  output logic [3:0]                bus_grant_o,
  // Clock routing
  output scsc_pkg::scsc_clk_t       clk_ctl_o,
  output logic                      sys_ctrl_o,
  output logic                      bp_ready_o,
  // EEPROM read port
  output logic [7:0]                ee_addr_o,
  input  wire logic [31:0]          ee_data_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic [31:0]               hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o
);

  typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_DONE, ST_OFF} scsc_ld_t;

  // Strap capture: three-stage sampler, value frozen at reset release
  scsc_pkg::scsc_straps_t s1_r, s2_r, s3_r, strap_r, strap_nxt;
  logic                   slot1_r, slot2_r, slot3_r, slot_r, slot_nxt;
  logic                   held_r, held_nxt;

  // No reset on the sampler: it must track the straps while reset is held,
  // otherwise the first agreeing sample after release is the cleared value
  always_ff @(posedge clk_i) begin
    s1_r    <= straps_i;
    s2_r    <= s1_r;
    s3_r    <= s2_r;
    slot1_r <= first_slot_i;
    slot2_r <= slot1_r;
    slot3_r <= slot2_r;
  end

  // Capture on the first agreeing sample after release, then freeze until next reset
  always_comb begin
    strap_nxt = strap_r;
    slot_nxt  = slot_r;
    held_nxt  = held_r;
    if (!held_r && s2_r == s3_r && slot2_r == slot3_r) begin
      strap_nxt = s3_r;
      slot_nxt  = slot3_r;
      held_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_r <= '0;
      slot_r  <= 1'b0;
      held_r  <= 1'b0;
    end else begin
      strap_r <= strap_nxt;
      slot_r  <= slot_nxt;
      held_r  <= held_nxt;
    end
  end

  // Role decision
  logic sc_role;
  always_comb begin
    sc_role = 1'b0;
    if (strap_r.slot_role_strap == scsc_pkg::ROLE_SC) begin
      sc_role = 1'b1;
    end else if (strap_r.slot_role_strap == scsc_pkg::ROLE_AUTO) begin
      sc_role = slot_r;
    end
    sc_role = sc_role & held_r;
  end

  // Loader
  scsc_ld_t               ld_r, ld_nxt;
  logic [7:0]             idx_r, idx_nxt;
  logic [31:0]            cfg_r [scsc_pkg::CFG_WORDS];
  logic [31:0]            ctrl_r, ctrl_nxt;
  logic [31:0]            wdat;
  logic                   reg_wr;
  logic [7:0]             wr_ofs;

  assign ee_addr_o = (strap_r.boot_image_select_strap ? scsc_pkg::FACTORY_BASE
                                                      : scsc_pkg::USER_BASE) + idx_r;

  always_comb begin
    ld_nxt  = ld_r;
    idx_nxt = idx_r;
    case (ld_r)
      ST_HOLD: begin
        if (held_r) begin
          ld_nxt = strap_r.self_config_disable_strap ? ST_OFF : ST_LOAD;
        end
      end
      ST_LOAD: begin
        idx_nxt = idx_r + 8'h01;
        if (idx_r == 8'(scsc_pkg::CFG_WORDS - 1)) begin
          ld_nxt = ST_DONE;
        end
      end
      default: ld_nxt = ld_r;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ld_r  <= ST_HOLD;
      idx_r <= 8'h00;
    end else begin
      ld_r  <= ld_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Loaded image words; word 0 overrides the arbitration control
  always_ff @(posedge clk_i) begin
    if (ld_r == ST_LOAD) begin
      cfg_r[idx_r[2:0]] <= ee_data_i;
    end
  end

  assign bp_ready_o = (ld_r == ST_DONE);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ld_r == ST_LOAD && idx_r == 8'h00) begin
      ctrl_nxt = ee_data_i;
    end else if (reg_wr && wr_ofs == scsc_pkg::OFS_CTRL) begin
      ctrl_nxt = wdat;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= scsc_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Clock routing; ctrl bit 6 lets software mute the system clock
  always_comb begin
    clk_ctl_o                 = '0;
    clk_ctl_o.sysclk_en       = sc_role & ctrl_r[6];
    clk_ctl_o.refclk_bp_drive = sc_role;
    clk_ctl_o.refclk_use_ext  = sc_role & strap_r.clock_source_strap;
    clk_ctl_o.refclk_ext_port = strap_r.external_clock_choice_strap;
    // Coax can only be an output when it is not the chosen external source
    clk_ctl_o.coax_out = strap_r.coax_clock_direction_strap
                         & ~(clk_ctl_o.refclk_use_ext & ~clk_ctl_o.refclk_ext_port);
    clk_ctl_o.port_out = strap_r.port_clock_direction_strap;
  end
  assign sys_ctrl_o = sc_role;

  // Arbiter: level 3 highest priority; ctrl[5] prioritized, else fixed anyway
  logic [3:0] gnt_r, gnt_nxt;
  always_comb begin
    gnt_nxt = 4'h0;
    if (sc_role && bp_ready_o) begin
      if (|(gnt_r & bus_req_i)) begin
        gnt_nxt = gnt_r; // Hold until the owner drops its request
      end else begin
        for (int i = 0; i < scsc_pkg::REQ_LEVELS; i++) begin
          if (bus_req_i[i]) begin
            gnt_nxt = 4'(1 << i);
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gnt_r <= 4'h0;
    end else begin
      gnt_r <= gnt_nxt;
    end
  end
  assign bus_grant_o = gnt_r;

  // AHB-Lite slave, zero wait states
  logic        ph_r, ph_nxt;
  logic        phw_r, phw_nxt;
  logic [7:0]  pha_r, pha_nxt;
  logic [31:0] rd_r, rd_nxt;

  always_comb begin
    ph_nxt  = 1'b0;
    phw_nxt = 1'b0;
    pha_nxt = pha_r;
    if (hsel_i && hready_i && htrans_i[1]) begin
      ph_nxt  = 1'b1;
      phw_nxt = hwrite_i;
      pha_nxt = haddr_i[7:0];
    end
  end
  assign reg_wr = ph_r & phw_r;
  assign wr_ofs = pha_r;
  assign wdat   = hwdata_i;

  always_comb begin
    if (haddr_i[7:0] == scsc_pkg::OFS_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (haddr_i[7:0] == scsc_pkg::OFS_STATUS) begin
      rd_nxt = {24'h0, gnt_r, 1'b0, held_r, bp_ready_o, sc_role};
    end else if (haddr_i[7:0] == scsc_pkg::OFS_STRAPS) begin
      rd_nxt = {23'h0, slot_r, strap_r};
    end else if (haddr_i[7:0] == scsc_pkg::OFS_ARB) begin
      rd_nxt = {28'h0, bus_req_i};
    end else begin
      rd_nxt = 32'h0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_r  <= 1'b0;
      phw_r <= 1'b0;
      pha_r <= 8'h00;
      rd_r  <= 32'h0;
    end else begin
      ph_r  <= ph_nxt;
      phw_r <= phw_nxt;
      pha_r <= pha_nxt;
      rd_r  <= rd_nxt;
    end
  end
  assign hrdata_o    = rd_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule // scsc_top

// ==== bench/scsc_eeprom_model.sv ====
`timescale 1ns/10ps
module scsc_eeprom_model (
  // EEPROM read port
  input  wire logic [7:0]  ee_addr_i,
  output logic      [31:0] ee_data_o
);
  // Distinct word 0 per half, so a read-back tells which half was loaded
  always_comb begin
    case (ee_addr_i)
      scsc_pkg::USER_BASE:    ee_data_o = 32'h0000_0072;
      scsc_pkg::FACTORY_BASE: ee_data_o = 32'h0000_0061;
      default:                ee_data_o = {24'h0, ee_addr_i};
    endcase
  end
endmodule // scsc_eeprom_model

// ==== bench/scsc_properties.sv ====
`timescale 1ns/10ps
module scsc_checker (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                nrst_i,
  // Watched ports
  input wire logic [3:0]          bus_req_i,
  input wire logic [3:0]          bus_grant_o,
  input wire scsc_pkg::scsc_clk_t clk_ctl_o,
  input wire logic                sys_ctrl_o,
  input wire logic                bp_ready_o,
  input wire logic                hreadyout_o,
  input wire logic                hresp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_arb_idle; sys_ctrl_o && bp_ready_o && bus_grant_o == 4'h0; endsequence
  sequence s_owned; (bus_grant_o & bus_req_i) != 4'h0; endsequence
  property p_onehot; $onehot0(bus_grant_o); endproperty
  property p_top_wins; s_arb_idle ##0 bus_req_i[3] |-> ##[1:2] bus_grant_o == 4'h8; endproperty
  property p_hold; s_owned |=> $stable(bus_grant_o); endproperty
  property p_to_req; bus_grant_o != 4'h0 |-> (bus_grant_o & $past(bus_req_i)) != 4'h0; endproperty
  property p_no_grant; !sys_ctrl_o || !bp_ready_o |-> bus_grant_o == 4'h0; endproperty
  property p_sysclk; clk_ctl_o.sysclk_en |-> sys_ctrl_o; endproperty
  property p_refclk; clk_ctl_o.refclk_bp_drive |-> sys_ctrl_o; endproperty
  property p_ready; bp_ready_o |=> bp_ready_o; endproperty
  // Straps are static: role and routing must not follow a jumper moved in service
  property p_held; bp_ready_o ##1 bp_ready_o |-> $stable(sys_ctrl_o) && $stable(clk_ctl_o[3:0]);
  endproperty
  property p_okay; hreadyout_o && !hresp_o; endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot");
  a_top_wins: assert property (p_top_wins) else $error("level 3 not granted");
  a_hold: assert property (p_hold) else $error("grant moved while owned");
  a_to_req: assert property (p_to_req) else $error("grant without request");
  a_no_grant: assert property (p_no_grant) else $error("grant while not ready");
  a_sysclk: assert property (p_sysclk) else $error("system clock outside role");
  a_refclk: assert property (p_refclk) else $error("reference driven outside role");
  a_ready: assert property (p_ready) else $error("ready dropped");
  a_held: assert property (p_held) else $error("strap result changed");
  a_okay: assert property (p_okay) else $error("bus answer not okay");
endmodule // scsc_checker

bind scsc_top scsc_checker scsc_checker_i (.clk_i, .nrst_i, .bus_req_i, .bus_grant_o,
  .clk_ctl_o, .sys_ctrl_o, .bp_ready_o, .hreadyout_o, .hresp_o);

// ==== bench/scsc_top_tb.sv ====
`timescale 1ns/10ps
`define chk(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module scsc_top_tb;
  typedef struct packed {
    scsc_pkg::scsc_straps_t st;
    logic                   fs;
    scsc_pkg::scsc_clk_t    ck;
    logic                   sc;
    logic [31:0]            ctrl;
    logic                   rdy;
  } scsc_row_t;
  scsc_row_t rows [5] = '{
    '{8'h40, 1'b1, 6'h30, 1'b1, 32'h0000_0072, 1'b1},
    '{8'h40, 1'b0, 6'h00, 1'b0, 32'h0000_0072, 1'b1},
    '{8'hbe, 1'b1, 6'h3f, 1'b1, 32'h0000_0061, 1'b1},
    '{8'h28, 1'b1, 6'h02, 1'b0, 32'h0000_0072, 1'b1},
    '{8'h41, 1'b1, 6'h30, 1'b1, 32'h0000_0073, 1'b0}};
  logic                   clk_i = 1'b0, nrst_i = 1'b0, first_slot_i = 1'b0;
  scsc_pkg::scsc_straps_t straps_i = 8'h40;
  logic [3:0]             bus_req_i = 4'h0;
  logic                   hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [1:0]             htrans_i = 2'h0;
  logic [31:0]            haddr_i = 32'h0, hwdata_i = 32'h0, ee_data, hrdata_o, rd;
  logic [7:0]             ee_addr;
  logic [3:0]             bus_grant_o;
  scsc_pkg::scsc_clk_t    clk_ctl_o;
  logic                   sys_ctrl_o, bp_ready_o, hreadyout_o, hresp_o;
  wire logic              hready_i = hreadyout_o;
  int                     bad_count = 0, compares = 0;
  always #25 clk_i = ~clk_i;
  scsc_top scsc_top_i (.clk_i, .nrst_i, .straps_i, .first_slot_i, .bus_req_i, .bus_grant_o,
    .clk_ctl_o, .sys_ctrl_o, .bp_ready_o, .ee_addr_o(ee_addr), .ee_data_i(ee_data), .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o);
  scsc_eeprom_model scsc_eeprom_model_i (.ee_addr_i(ee_addr), .ee_data_o(ee_data));
  task end_of_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hready is always sampled at the edge; a stuck slave ends the run
  task automatic step_rdy;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      if (++n > 20) begin
        bad_count++;
        end_of_test();
      end
      @(posedge clk_i);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1; haddr_i <= a; htrans_i <= 2'h2; hwrite_i <= w;
    step_rdy();
    hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= d;
    step_rdy();
    rd = hrdata_o;
  endtask
  task automatic do_reset(input scsc_pkg::scsc_straps_t s, input logic f);
    int n;
    straps_i <= s; first_slot_i <= f; nrst_i <= 1'b0; bus_req_i <= 4'h0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (n = 0; n < 40 && bp_ready_o !== 1'b1; n++) @(posedge clk_i);
  endtask
  task automatic grant_is(input logic [3:0] g);
    int n;
    for (n = 0; n < 10 && bus_grant_o !== g; n++) @(posedge clk_i);
    `chk(bus_grant_o, g)
  endtask
  initial begin
    @(posedge clk_i);
    foreach (rows[i]) begin
      do_reset(rows[i].st, rows[i].fs);
      `chk(bp_ready_o, rows[i].rdy)
      `chk(sys_ctrl_o, rows[i].sc)
      `chk(clk_ctl_o, rows[i].ck)
      ahb(1'b0, 32'h0, 32'h0);
      `chk(rd, rows[i].ctrl)
    end
    do_reset(8'h40, 1'b1);
    bus_req_i <= 4'ha;
    grant_is(4'h8);
    bus_req_i <= 4'h2;
    grant_is(4'h2);
    bus_req_i <= 4'ha;
    repeat (3) @(posedge clk_i);
    grant_is(4'h2);
    bus_req_i <= 4'h8;
    grant_is(4'h8);
    straps_i <= 8'h00;
    repeat (3) @(posedge clk_i);
    `chk(sys_ctrl_o, 1'b1)
    ahb(1'b1, 32'h0, 32'h0000_0031);
    ahb(1'b1, 32'h4, 32'hffff_ffff);
    ahb(1'b0, 32'h0, 32'h0);
    `chk(rd, 32'h0000_0031)
    `chk(clk_ctl_o.sysclk_en, 1'b0)
    ahb(1'b0, 32'h20, 32'h0);
    `chk(rd, 32'h0)
    ahb(1'b0, 32'h4, 32'h0);
    `chk(rd, 32'h0000_0087)
    ahb(1'b0, 32'h8, 32'h0);
    `chk(rd, 32'h0000_0140)
    ahb(1'b0, 32'hc, 32'h0);
    `chk(rd, 32'h0000_0008)
    // Forced non-controller: requests must go unanswered
    do_reset(8'h00, 1'b0);
    bus_req_i <= 4'hf;
    repeat (3) @(posedge clk_i);
    grant_is(4'h0);
    end_of_test();
  end
endmodule // scsc_top_tb
